//--- timer_regs.vh
// Register map, field positions and reset values of the reloadable timer
// Assumes a 32-bit APB slave decoding word-aligned byte addresses
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// Byte offsets of the registers
`define TMR_CTRL_OFS     12'h000
`define TMR_COUNT_OFS    12'h004
`define TMR_RELOAD_OFS   12'h008
`define TMR_STATUS_OFS   12'h00C

// Control register fields
`define CTRL_EN_BIT      0
`define CTRL_MODE_LSB    1
`define CTRL_MODE_MSB    2
`define CTRL_PRE_LSB     3
`define CTRL_PRE_MSB     5
`define CTRL_POL_BIT     6
`define CTRL_OUTEN_BIT   7
`define CTRL_WIDTH       8

// Status register fields
`define STAT_IRQ_BIT     0
`define STAT_OUT_BIT     1

// Mode encodings
`define MODE_ONESHOT     2'h0
`define MODE_CONT        2'h1
`define MODE_COUNTER     2'h2

// Reset values and fixed counts
`define CTRL_RESET       8'h00
`define COUNT_RESET      16'h0000
`define RELOAD_RESET     16'h0000
`define COUNT_RESTART    16'h0001
`define COUNT_STEP       16'h0001
`define PRE_ZERO         7'h00
`define PRE_ONE          7'h01

`endif

//--- edge_sync.v
// Two-stage synchroniser with edge detection on the synchronised level
// Assumes din is asynchronous to clk; edge pulses last one cycle
`timescale 1ns/1ps

module edge_sync (
    // Clock and reset
    input  wire clk,
    input  wire rst_n,
    // Asynchronous input
    input  wire din,
    // Synchronised level and one-cycle edge pulses
    output reg  level_q,
    output wire rise,
    output wire fall
);

    reg meta_q;
    reg sync_q;

    // Two flops, then a history flop for edge detection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q  <= 1'b0;
            sync_q  <= 1'b0;
            level_q <= 1'b0;
        end else begin
            meta_q  <= din;
            sync_q  <= meta_q;
            level_q <= sync_q;
        end
    end

    // Edges seen on the synchronised signal only
    assign rise = sync_q & ~level_q;
    assign fall = ~sync_q & level_q;

endmodule // edge_sync

//--- reloadable_timer_16bit.v
// 16-bit reloadable up-counting timer with prescaler and APB registers
// Assumes an APB master on pclk and an asynchronous timer input pin
//
// Notes on behaviour
// - Sixteen-bit up-counter; all-ones wraps to zero and keeps counting.
// - Prescaler divides the clock by 1 to 128 before advancing.
// - Reload of zero means a full 65536-count period, longest time-out.
// - Reload one with division one gives the shortest time-out.
// - One-shot reload raises interrupt, count becomes one, enable clears.
// - One-shot with output on inverts the pin for one cycle unless polarity changed after the start.
// - One-shot and continuous modes count prescaled clock, never the pin.
// - Continuous reload raises interrupt, count becomes one, keeps running.
// - Continuous and counter modes toggle the output at every reload.
// - Written start count affects first pass only; reloads restart at one.
// - Counter mode counts input edges; polarity picks rising or falling.
// - Counter mode bypasses the prescaler; one edge advances one.
// - Counter reload raises interrupt, count becomes one, keeps counting.
// - In counter mode the polarity also sets the output start level.
// - One-shot time-out is (reload minus start) times the division.
// - Later continuous periods last reload times the division.
// - Counter mode counts exactly once per qualifying edge.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "timer_regs.vh"

module reloadable_timer_16bit (
    // APB clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Timer pins
    input  wire        timer_in,
    output reg         timer_out,
    output reg         timer_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    reg  [7:0]  ctrl_q;
    reg  [15:0] count_q;
    reg  [15:0] reload_q;
    reg  [6:0]  pre_q;
    reg         irq_flag_q;
    reg         first_q;
    reg         out_lvl_q;

    wire        en       = ctrl_q[`CTRL_EN_BIT];
    wire [1:0]  mode     = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    wire [2:0]  pre_sel  = ctrl_q[`CTRL_PRE_MSB:`CTRL_PRE_LSB];
    wire        pol      = ctrl_q[`CTRL_POL_BIT];
    wire        out_en   = ctrl_q[`CTRL_OUTEN_BIT];

    // Bus strobes, taken in the access phase
    wire        acc      = psel & penable;
    wire        wr       = acc & pwrite;
    wire        wr_ctrl  = wr & (paddr == `TMR_CTRL_OFS);
    wire        wr_count = wr & (paddr == `TMR_COUNT_OFS);
    wire        wr_rel   = wr & (paddr == `TMR_RELOAD_OFS);
    wire        wr_stat  = wr & (paddr == `TMR_STATUS_OFS);
    wire        mapped   = (paddr == `TMR_CTRL_OFS) |
                           (paddr == `TMR_COUNT_OFS) |
                           (paddr == `TMR_RELOAD_OFS) |
                           (paddr == `TMR_STATUS_OFS);

    ////////////////////////////////////////////////////////////////////////
    // Input pin synchroniser

    wire in_rise;
    wire in_fall;

    edge_sync u_sync (
        .clk     (pclk),
        .rst_n   (presetn),
        .din     (timer_in),
        .level_q (),
        .rise    (in_rise),
        .fall    (in_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Tick generation

    // Division mask: 2^pre_sel - 1, terminal count of the prescaler
    wire [6:0] pre_last = (`PRE_ONE << pre_sel) - `PRE_ONE;
    wire       pre_tick = (pre_q == pre_last);
    // Edge picked by polarity: 1 rising, 0 falling
    wire       edge_hit = pol ? in_rise : in_fall;
    wire       is_cnt   = (mode == `MODE_COUNTER);
    // Counter mode bypasses the prescaler; timed modes use it only
    wire       tick     = en & (is_cnt ? edge_hit : pre_tick);
    wire [15:0] next_cnt = count_q + `COUNT_STEP;
    // First pass matches on the advanced value so it lasts reload minus
    // start; later passes match on the shown value, a full reload period
    wire       match    = first_q ? (next_cnt == reload_q)
                                  : (count_q == reload_q);
    wire       hit      = tick & match;

    // Prescaler, cleared while disabled so enable restarts it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= `PRE_ZERO;
        end else if (!en || wr_ctrl || is_cnt || pre_tick) begin
            pre_q <= `PRE_ZERO;
        end else begin
            pre_q <= pre_q + `PRE_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter, control and reload registers

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= `CTRL_RESET;
            count_q  <= `COUNT_RESET;
            reload_q <= `RELOAD_RESET;
            first_q  <= 1'b1;
        end else begin
            // First-pass marker, rearmed by a control or count write, not by a reload write
            if (wr_ctrl || wr_count) begin
                first_q <= 1'b1;
            end else if (hit) begin
                first_q <= 1'b0;
            end
            if (wr_rel) begin
                reload_q <= pwdata[15:0];
            end
            if (wr_ctrl) begin
                ctrl_q <= pwdata[`CTRL_WIDTH-1:0];
            end else if (hit && mode == `MODE_ONESHOT) begin
                ctrl_q[`CTRL_EN_BIT] <= 1'b0;
            end
            // Software write wins only if no reload happens this cycle
            if (hit) begin
                count_q <= `COUNT_RESTART;
            end else if (wr_count) begin
                count_q <= pwdata[15:0];
            end else if (tick) begin
                count_q <= next_cnt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output pin and interrupt

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_lvl_q  <= 1'b0;
            irq_flag_q <= 1'b0;
            timer_out  <= 1'b0;
            timer_irq  <= 1'b0;
        end else begin
            // Disabled: level follows polarity; one-shot self-disable
            // restores it the cycle after the inversion
            if (!en) begin
                out_lvl_q <= pol;
            end else if (hit) begin
                out_lvl_q <= ~out_lvl_q;
            end
            if (!out_en) begin
                timer_out <= 1'b0;
            end else begin
                timer_out <= out_lvl_q;
            end
            // Sticky flag; a set in the clear cycle wins
            if (hit) begin
                irq_flag_q <= 1'b1;
            end else if (wr_stat && pwdata[`STAT_IRQ_BIT]) begin
                irq_flag_q <= 1'b0;
            end
            timer_irq <= hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read and response

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `TMR_CTRL_OFS:   prdata[7:0]  <= ctrl_q;
                    `TMR_COUNT_OFS:  prdata[15:0] <= count_q;
                    `TMR_RELOAD_OFS: prdata[15:0] <= reload_q;
                    `TMR_STATUS_OFS: begin
                        prdata[`STAT_IRQ_BIT] <= irq_flag_q;
                        prdata[`STAT_OUT_BIT] <= timer_out;
                    end
                    default:         prdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // reloadable_timer_16bit

//--- timer_props_properties.sv
// Concurrent checks on the reloadable timer top-level ports
// Assumes zero-wait APB slave and the register map of timer_regs.vh
`timescale 1ns/1ps
module timer_props (
    // Clock, reset and APB
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Timer pins
    input wire        timer_out,
    input wire        timer_irq
);
    reg  [7:0]  ctl_q;
    reg  [15:0] rl_q;
    reg  [23:0] gap_q;
    reg         arm_q;
    wire        wr = psel & penable & pready & pwrite;
    wire [23:0] per = {7'h00, rl_q == 16'h0000, rl_q} << ctl_q[5:3];
    // Shadows of control and reload, cycles since the last interrupt
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 8'h00;
            rl_q  <= 16'h0000;
            gap_q <= 24'h000000;
            arm_q <= 1'b0;
        end else begin
            if (wr && paddr == 12'h000)
                ctl_q <= pwdata[7:0];
            if (wr && paddr == 12'h008)
                rl_q <= pwdata[15:0];
            gap_q <= timer_irq ? 24'h000001 : gap_q + 24'h000001;
            arm_q <= (wr && paddr != 12'h00C) ? 1'b0 : (timer_irq | arm_q);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_pready_now;
        psel && !penable |=> pready;
    endproperty
    a_pready_now: assert property (p_pready_now) else $error("no ready");
    property p_pready_one;
        psel && penable && pready |=> !pready;
    endproperty
    a_pready_one: assert property (p_pready_one) else $error("long ready");
    property p_err_map;
        psel && penable && pready |-> pslverr ==
            !(paddr == 12'h000 || paddr == 12'h004 ||
              paddr == 12'h008 || paddr == 12'h00C);
    endproperty
    a_err_map: assert property (p_err_map) else $error("bad pslverr");
    property p_err_zero;
        pready && pslverr && !pwrite |-> prdata == 32'h00000000;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("bad err data");
    property p_irq_pulse;
        timer_irq |=> !timer_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("long irq");
    property p_cont_period;
        timer_irq && arm_q && ctl_q[2:1] == 2'h1 |-> gap_q == per;
    endproperty
    a_cont_period: assert property (p_cont_period) else $error("period");
    property p_out_toggle;
        timer_irq && ctl_q[7] && ctl_q[2:1] != 2'h0 |-> ##[0:2] $changed(timer_out);
    endproperty
    a_out_toggle: assert property (p_out_toggle) else $error("no toggle");
    property p_shot_pulse;
        ctl_q[2:1] == 2'h0 && ctl_q[7] && $changed(timer_out)
            && timer_out != ctl_q[6] |=> timer_out == ctl_q[6];
    endproperty
    a_shot_pulse: assert property (p_shot_pulse) else $error("pulse");
endmodule // timer_props

bind reloadable_timer_16bit timer_props u_timer_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_out(timer_out),
    .timer_irq(timer_irq));

//--- pin_drv.sv
// Outside signal source on the timer input pin
// Assumes pulses() is called just after a pclk edge
`timescale 1ns/1ps
module pin_drv (
    // Clock
    input wire pclk,
    // Driven pin
    output reg pin
);
    initial pin = 1'b0;
    // One rise and one fall per pulse, each level held four clocks
    task pulses(input integer n);
        begin
            repeat (n) begin
                pin <= 1'b1;
                repeat (4) @(posedge pclk);
                pin <= 1'b0;
                repeat (4) @(posedge pclk);
            end
            repeat (6) @(posedge pclk);
        end
    endtask
endmodule // pin_drv

//--- tb_top.sv
// Self-checking bench for the reloadable timer over APB
// Assumes zero-wait APB answers and a 20 MHz pclk
`timescale 1ns/1ps
`include "timer_regs.vh"
module tb_top;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h00000000;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        timer_in;
    wire        timer_out;
    wire        timer_irq;
    integer     fail_count = 0;
    integer     n_checks = 0;
    integer     irq_n = 0;
    integer     k;
    integer     i;
    reg  [31:0] rd;
    reg         err;
    initial forever #25 pclk = ~pclk;
    // Interrupt pulse counter
    always @(posedge pclk) if (timer_irq === 1'b1) irq_n = irq_n + 1;
    reloadable_timer_16bit u_reloadable_timer_16bit (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_in(timer_in), .timer_out(timer_out),
        .timer_irq(timer_irq));
    pin_drv u_pin_drv (.pclk(pclk), .pin(timer_in));
    ////////////////////////////////////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input wr, input [11:0] a, input [31:0] d);
        begin
            // Idle edge so a release and a new request never share a step
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do begin
                @(posedge pclk);
            end while (pready !== 1'b1);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wait_irq;
        begin
            k = 0;
            do begin
                @(posedge pclk);
                k = k + 1;
            end while (timer_irq !== 1'b1 && k < 300);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset values and an unmapped read
    task t_regs;
        for (i = 0; i < 5; i = i + 1) begin
            apb(1'b0, i * 4, 32'h00000000);
            chk(rd, 32'h00000000);
            chk({31'h0, err}, {31'h0, i == 4});
        end
    endtask
    // One-shot from FFFF across the wrap
    task t_shot;
        begin
            apb(1'b1, `TMR_RELOAD_OFS, 32'h00000002);
            apb(1'b1, `TMR_COUNT_OFS, 32'h0000FFFF);
            apb(1'b1, `TMR_CTRL_OFS, 32'h00000081);
            wait_irq;
            chk(k, 4);
            @(posedge pclk);
            chk(timer_out, 1'b1);
            @(posedge pclk);
            chk(timer_out, 1'b0);
            apb(1'b0, `TMR_CTRL_OFS, 32'h00000000);
            chk(rd[0], 1'b0);
            apb(1'b0, `TMR_COUNT_OFS, 32'h00000000);
            chk(rd, 32'h00000001);
        end
    endtask
    // One-shot lasting level: polarity inverted after the start
    task t_level;
        begin
            apb(1'b1, `TMR_CTRL_OFS, 32'h00000080);
            apb(1'b1, `TMR_COUNT_OFS, 32'h00000001);
            apb(1'b1, `TMR_RELOAD_OFS, 32'h00000020);
            apb(1'b1, `TMR_CTRL_OFS, 32'h00000081);
            apb(1'b1, `TMR_CTRL_OFS, 32'h000000C1);
            chk(timer_out, 1'b0);
            wait_irq;
            repeat (3) @(posedge pclk);
            chk(timer_out, 1'b1);
        end
    endtask
    // Continuous, division four
    task t_cont;
        begin
            apb(1'b1, `TMR_CTRL_OFS, 32'h00000000);
            apb(1'b1, `TMR_COUNT_OFS, 32'h00000001);
            apb(1'b1, `TMR_RELOAD_OFS, 32'h00000003);
            apb(1'b1, `TMR_CTRL_OFS, 32'h00000093);
            wait_irq;
            chk(k, 9);
            wait_irq;
            chk(k, 12);
            apb(1'b0, `TMR_STATUS_OFS, 32'h00000000);
            chk(rd[0], 1'b1);
            apb(1'b1, `TMR_CTRL_OFS, 32'h00000000);
        end
    endtask
    // Counter mode with the prescaler field at its largest
    task t_cnt;
        begin
            apb(1'b1, `TMR_COUNT_OFS, 32'h00000001);
            apb(1'b1, `TMR_RELOAD_OFS, 32'h00000005);
            apb(1'b1, `TMR_CTRL_OFS, 32'h000000FD);
            u_pin_drv.pulses(3);
            apb(1'b0, `TMR_COUNT_OFS, 32'h00000000);
            chk(rd, 32'h00000004);
            k = irq_n;
            u_pin_drv.pulses(1);
            chk(irq_n - k, 1);
            apb(1'b0, `TMR_COUNT_OFS, 32'h00000000);
            chk(rd, 32'h00000001);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Hang guard
    initial begin
        #2000000;
        fail_count = fail_count + 1;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test;
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_shot;
        t_level;
        t_cont;
        t_cnt;
        finish_test;
    end
endmodule // tb_top
